// ---- rtl/hdc_pkg.sv ----
// package: constants, field layout and carrier types of the halting debug control block
// Operation
// R1: with debug enabled, mask bit set masks service call, tick and external interrupts
// R2: debugger changes mask only while halted and writing halt as 1; code takes the mask bit on any keyed write, halted or not
// R3: mask never blocks the non-maskable interrupt
// R4: with debug disabled the mask bit value reads as don't-care
// R5: step bit written 1 enables single-step, 0 disables it
// R6: halt bit written 1 requests halt, 0 requests resume
// R7: enable bit 0 disables halting debug, 1 enables it
// R8: debugger setting enable from 0 to 1 writes mask 0 too; code takes the written mask bit and never forces it to 0
// R9: enable bit changes only from debug access port, processor writes ignored
// R10: after power-on reset enable bit is 0
// R11: selector write picks target register and direction and starts transfer
// R12: selector only acts in Debug state; other writes start nothing
// R13: control writes ignored unless upper half carries the unlock key
// R14: debugger loads data register first, then writes selector with direction
// R15: selector write clears ready flag, transfer completion sets it
package hdc_pkg;
  // register select codes on the access port
  localparam logic [1:0]  SEL_CTRL_STATUS = 2'h0;
  localparam logic [1:0]  SEL_XFER_SELECT = 2'h1;
  localparam logic [1:0]  SEL_XFER_DATA   = 2'h2;
  // control and status register fields
  localparam int          KEY_LSB         = 16;
  localparam logic [15:0] WRITE_UNLOCK_KEY = 16'hA05F;
  localparam int          BIT_DEBUG_EN    = 0;
  localparam int          BIT_HALT        = 1;
  localparam int          BIT_STEP        = 2;
  localparam int          BIT_INT_MASK    = 3;
  localparam int          BIT_READY       = 16;
  localparam int          BIT_HALTED      = 17;
  // selector fields
  localparam int          BIT_DIRECTION   = 16;
  localparam int          REGCODE_W       = 5;
  // reset values
  localparam logic        RST_DEBUG_EN    = 1'b0;
  localparam logic        RST_HALT        = 1'b0;
  localparam logic        RST_STEP        = 1'b0;
  localparam logic        RST_INT_MASK    = 1'b0;
  localparam logic        RST_READY       = 1'b1;
  localparam logic [31:0] RST_DATA        = 32'h0000_0000;
  // interrupt widths
  localparam int          EXT_IRQ_W       = 32;
  // direction encoding
  localparam logic        DIR_READ        = 1'b0;
  localparam logic        DIR_WRITE       = 1'b1;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_dap;
    logic [1:0]  sel;
    logic [31:0] wdata;
  } hdc_acc_t;

  typedef struct packed {
    logic                 valid;
    logic                 dir;
    logic [REGCODE_W-1:0] target_register_code;
    logic [31:0]          wdata;
  } hdc_xreq_t;
endpackage

// ---- rtl/hdc_top.sv ----
// halting debug control register and core register transfer front end
`timescale 1ns/1ps
module hdc_top (
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          ce_i,
  // register access port
  input  hdc_pkg::hdc_acc_t                  acc_i,
  output logic [31:0]                        rdata_o,
  output logic                               rvalid_o,
  // processor debug state
  input  wire logic                          in_debug_i,
  output logic                               debug_en_o,
  output logic                               halt_req_o,
  output logic                               step_en_o,
  // interrupt gating
  input  wire logic                          pended_service_call_i,
  input  wire logic                          system_tick_interrupt_i,
  input  wire logic [hdc_pkg::EXT_IRQ_W-1:0] ext_irq_i,
  input  wire logic                          nmi_i,
  output logic                               pended_service_call_o,
  output logic                               system_tick_interrupt_o,
  output logic [hdc_pkg::EXT_IRQ_W-1:0]      ext_irq_o,
  output logic                               nmi_o,
  // core register transfer
  output hdc_pkg::hdc_xreq_t                 xreq_o,
  input  wire logic                          xfer_done_i,
  input  wire logic [31:0]                   xfer_rdata_i
);
  import hdc_pkg::*;

  logic        debug_en;
  logic        halt;
  logic        step;
  logic        int_mask;
  logic        eff_mask;
  logic        key_ok;
  logic        ctrl_wr;
  logic        sel_wr;
  logic        data_wr;
  logic        rd;
  logic        ready;
  logic        busy;
  logic [31:0] data_reg;
  logic [31:0] next_rdata;

  // access decode
  assign key_ok  = acc_i.wdata[31:KEY_LSB] == WRITE_UNLOCK_KEY; // R13
  assign ctrl_wr = ce_i && acc_i.valid && acc_i.write
                   && acc_i.sel == SEL_CTRL_STATUS && key_ok; // R13
  assign sel_wr  = acc_i.valid && acc_i.write && acc_i.sel == SEL_XFER_SELECT;
  assign data_wr = acc_i.valid && acc_i.write && acc_i.sel == SEL_XFER_DATA;
  assign rd      = ce_i && acc_i.valid && !acc_i.write;

  // halting debug enable, debug access port only
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      debug_en <= RST_DEBUG_EN; // R10
    end else if (ctrl_wr && acc_i.from_dap) begin
      debug_en <= acc_i.wdata[BIT_DEBUG_EN]; // R7 R9
    end
  end

  // halt request bit
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt <= RST_HALT;
    end else if (ctrl_wr) begin
      halt <= acc_i.wdata[BIT_HALT]; // R6
    end
  end

  // single-step bit
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step <= RST_STEP;
    end else if (ctrl_wr) begin
      step <= acc_i.wdata[BIT_STEP]; // R5
    end
  end

  // interrupt mask bit; debugger keeps the halt and enable sequencing
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_mask <= RST_INT_MASK;
    end else if (ctrl_wr) begin
      int_mask <= acc_i.wdata[BIT_INT_MASK]; // R2 R8
    end
  end

  // effects on the processor
  assign eff_mask   = debug_en && int_mask; // R1
  assign debug_en_o = debug_en; // R7
  assign halt_req_o = debug_en && halt; // R6
  assign step_en_o  = debug_en && step; // R5
  assign pended_service_call_o   = pended_service_call_i && !eff_mask; // R1
  assign system_tick_interrupt_o  = system_tick_interrupt_i && !eff_mask; // R1

  genvar gi;
  generate
    for (gi = 0; gi < EXT_IRQ_W; gi++) begin : g_irq
      assign ext_irq_o[gi] = ext_irq_i[gi] && !eff_mask; // R1
    end
  endgenerate

  assign nmi_o = nmi_i; // R3

  // transfer engine
  hdc_xfer u_xfer (
    .mclk_i       (mclk_i),
    .arst_n_i     (arst_n_i),
    .ce_i         (ce_i),
    .start_i      (sel_wr),
    .dir_i        (acc_i.wdata[BIT_DIRECTION]),
    .target_register_code_i     (acc_i.wdata[REGCODE_W-1:0]),
    .data_wr_i    (data_wr),
    .data_i       (acc_i.wdata),
    .in_debug_i   (in_debug_i),
    .ready_o      (ready),
    .busy_o       (busy),
    .data_o       (data_reg),
    .xreq_o       (xreq_o),
    .done_i       (xfer_done_i),
    .core_rdata_i (xfer_rdata_i)
  );

  // read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (acc_i.sel)
      SEL_CTRL_STATUS: begin
        next_rdata[BIT_HALTED]   = in_debug_i;
        next_rdata[BIT_READY]    = ready;
        next_rdata[BIT_INT_MASK] = eff_mask; // R4
        next_rdata[BIT_STEP]     = step;
        next_rdata[BIT_HALT]     = halt;
        next_rdata[BIT_DEBUG_EN] = debug_en;
      end
      SEL_XFER_DATA: begin
        next_rdata = data_reg;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd) begin
      rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_o <= 1'b0;
    end else if (ce_i) begin
      rvalid_o <= acc_i.valid && !acc_i.write;
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // unlock key and write source
  a_key_guard_ctrl: assert property ( // R13
    (ce_i && acc_i.valid && acc_i.write && acc_i.sel == SEL_CTRL_STATUS && !key_ok)
    |=> $stable({debug_en, halt, step, int_mask}))
    else $error("control bits changed without unlock key");

  a_sw_enable_ignored: assert property ( // R9
    (ctrl_wr && !acc_i.from_dap)
    |=> $stable(debug_en_o))
    else $error("processor write changed debug enable");

  a_enable_holds: assert property ( // R9
    !(ctrl_wr && acc_i.from_dap)
    |=> $stable(debug_en))
    else $error("debug enable changed without port write");

  // control bits
  a_enable_write: assert property ( // R7
    (ctrl_wr && acc_i.from_dap)
    |=> debug_en_o == $past(acc_i.wdata[BIT_DEBUG_EN]))
    else $error("debug enable did not take written value");

  a_halt_request: assert property ( // R5 R6
    (ctrl_wr && acc_i.from_dap && acc_i.wdata[BIT_DEBUG_EN])
    |=> halt_req_o == $past(acc_i.wdata[BIT_HALT])
        && step_en_o == $past(acc_i.wdata[BIT_STEP]))
    else $error("halt or step request wrong after write");

  a_sw_halt_write: assert property ( // R5 R6
    ctrl_wr
    |=> halt == $past(acc_i.wdata[BIT_HALT]) && step == $past(acc_i.wdata[BIT_STEP]))
    else $error("halt or step bit did not take written value");

  a_halt_holds: assert property ( // R6
    !ctrl_wr
    |=> $stable(halt))
    else $error("halt bit changed without keyed write");

  a_step_holds: assert property ( // R5
    !ctrl_wr
    |=> $stable(step))
    else $error("step bit changed without keyed write");

  a_mask_holds: assert property ( // R1
    !ctrl_wr
    |=> $stable(int_mask))
    else $error("mask bit changed without keyed write");

  a_disabled_quiet: assert property ( // R7
    !debug_en
    |-> !halt_req_o && !step_en_o)
    else $error("halt or step request while debug disabled");

  // interrupt gating
  a_mask_gates_irq: assert property ( // R1
    (debug_en && int_mask)
    |-> (!pended_service_call_o && !system_tick_interrupt_o && ext_irq_o == '0))
    else $error("masked interrupt passed");

  a_mask_needs_enable: assert property ( // R1
    (!debug_en)
    |-> (pended_service_call_o == pended_service_call_i && system_tick_interrupt_o == system_tick_interrupt_i))
    else $error("interrupt masked while debug disabled");

  a_unmasked_pass: assert property ( // R1
    !eff_mask
    |-> ext_irq_o == ext_irq_i && pended_service_call_o == pended_service_call_i && system_tick_interrupt_o == system_tick_interrupt_i)
    else $error("interrupt blocked without mask");

  a_nmi_passes: assert property ( // R3
    (eff_mask && nmi_i)
    |-> nmi_o)
    else $error("nmi blocked by mask");

  a_nmi_follows: assert property ( // R3
    (eff_mask && !nmi_i)
    |-> !nmi_o)
    else $error("nmi raised without request");

  // read answers
  a_read_answer: assert property ( // R4
    (ce_i && acc_i.valid && !acc_i.write)
    |=> rvalid_o ##1 (!rvalid_o || $past(rd)))
    else $error("read answer missing");

  a_mask_reads_zero: assert property ( // R4
    (rd && acc_i.sel == SEL_CTRL_STATUS && !debug_en)
    |=> !rdata_o[BIT_INT_MASK])
    else $error("mask bit read as set while debug disabled");

  a_status_fields: assert property ( // R15
    (rd && acc_i.sel == SEL_CTRL_STATUS)
    |=> rdata_o[BIT_READY] == $past(ready) && rdata_o[BIT_HALTED] == $past(in_debug_i))
    else $error("status bits read wrong");

  // transfers
  a_ready_clear: assert property ( // R11 R15
    (ce_i && sel_wr && in_debug_i && !busy)
    |=> !ready && xreq_o.valid && xreq_o.target_register_code == $past(acc_i.wdata[REGCODE_W-1:0]))
    else $error("selector write did not start transfer");

  a_no_start_outside: assert property ( // R12
    (ce_i && sel_wr && !in_debug_i && !busy)
    |=> !xreq_o.valid && ready)
    else $error("transfer started outside debug state");

  a_ready_set: assert property ( // R15
    (ce_i && busy && xfer_done_i)
    |=> ready && !xreq_o.valid)
    else $error("ready flag not set on completion");

  a_busy_no_ready: assert property ( // R15
    busy
    |-> !ready)
    else $error("ready flag high during transfer");

  a_busy_keeps_sel: assert property ( // R11
    (ce_i && sel_wr && busy)
    |=> $stable(xreq_o.dir) && $stable(xreq_o.target_register_code))
    else $error("selector changed during transfer");

  a_read_fetch: assert property ( // R11
    (ce_i && busy && xfer_done_i && xreq_o.dir == DIR_READ)
    |=> data_reg == $past(xfer_rdata_i))
    else $error("read transfer did not load data register");

  a_busy_data_hold: assert property ( // R14
    (busy && !(ce_i && xfer_done_i))
    |=> $stable(data_reg))
    else $error("data register changed during transfer");

  c_write_xfer: cover property (
    (sel_wr && ce_i && in_debug_i && acc_i.wdata[BIT_DIRECTION]) ##[1:20] (busy && xfer_done_i));

  c_read_xfer: cover property (
    (sel_wr && ce_i && in_debug_i && !acc_i.wdata[BIT_DIRECTION]) ##[1:20] (busy && xfer_done_i));

  c_mask_active: cover property (eff_mask && pended_service_call_i && nmi_i);

  c_key_refused: cover property (
    ce_i && acc_i.valid && acc_i.write && acc_i.sel == SEL_CTRL_STATUS && !key_ok);

  c_sw_write: cover property (ctrl_wr && !acc_i.from_dap);
endmodule // hdc_top

// ---- rtl/hdc_xfer.sv ----
// core register transfer engine: selector, data register, ready flag
`timescale 1ns/1ps
module hdc_xfer (
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          ce_i,
  // control side
  input  wire logic                          start_i,
  input  wire logic                          dir_i,
  input  wire logic [hdc_pkg::REGCODE_W-1:0] target_register_code_i,
  input  wire logic                          data_wr_i,
  input  wire logic [31:0]                   data_i,
  input  wire logic                          in_debug_i,
  output logic                               ready_o,
  output logic                               busy_o,
  output logic [31:0]                        data_o,
  // core side
  output hdc_pkg::hdc_xreq_t                 xreq_o,
  input  wire logic                          done_i,
  input  wire logic [31:0]                   core_rdata_i
);
  import hdc_pkg::*;

  typedef enum logic {
    HDC_IDLE = 1'b0,
    HDC_BUSY = 1'b1
  } hdc_xstate_t;

  hdc_xstate_t          state;
  logic                 accept;
  logic                 finish;
  logic                 dir;
  logic [REGCODE_W-1:0] target_register_code;

  assign accept = ce_i && start_i && in_debug_i && (state == HDC_IDLE); // R11 R12
  assign finish = ce_i && done_i && (state == HDC_BUSY);
  assign busy_o = (state == HDC_BUSY);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= HDC_IDLE;
    end else if (accept) begin
      state <= HDC_BUSY;
    end else if (finish) begin
      state <= HDC_IDLE;
    end
  end

  // ready flag handshake
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_o <= RST_READY;
    end else if (accept) begin
      ready_o <= 1'b0; // R15
    end else if (finish) begin
      ready_o <= 1'b1; // R15
    end
  end

  // selector latch toward the core
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir    <= DIR_READ;
      target_register_code <= '0;
    end else if (accept) begin
      dir    <= dir_i; // R11
      target_register_code <= target_register_code_i; // R11
    end
  end

  // request carrier, one driver for the whole struct
  always_comb begin
    xreq_o.valid  = busy_o;
    xreq_o.dir    = dir;
    xreq_o.target_register_code = target_register_code;
    xreq_o.wdata  = data_o;
  end

  // data register, loaded by debugger or by a finished read
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= RST_DATA;
    end else if (finish && dir == DIR_READ) begin
      data_o <= core_rdata_i;
    end else if (ce_i && data_wr_i && state == HDC_IDLE) begin
      data_o <= data_i; // R14
    end
  end
endmodule // hdc_xfer

// ---- tb/hdc_core_model.sv ----
// core-side model: register file answering transfer requests after a set delay
`timescale 1ns/1ps
module hdc_core_model (
  // clock and reset
  input  wire logic          mclk_i,
  input  wire logic          arst_n_i,
  // transfer request and answer
  input  hdc_pkg::hdc_xreq_t xreq_i,
  input  wire logic [3:0]    delay_i,
  output logic               done_o,
  output logic [31:0]        rdata_o
);
  import hdc_pkg::*;
  logic [31:0] core_reg [32];
  logic [3:0]  wait_cnt;
  // one done pulse per request, after delay_i plus one waiting cycles
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_cnt <= 4'h0;
      done_o   <= 1'b0;
    end else if (!xreq_i.valid || done_o) begin
      wait_cnt <= 4'h0;
      done_o   <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      done_o   <= (wait_cnt == delay_i);
    end
  end
  // selected register takes the data word on a write transfer
  always_ff @(posedge mclk_i) begin
    if (done_o && xreq_i.dir == DIR_WRITE) begin
      core_reg[xreq_i.target_register_code] <= xreq_i.wdata;
    end
  end
  // read value only valid with done, inverted otherwise
  assign rdata_o = done_o ? core_reg[xreq_i.target_register_code] : ~core_reg[xreq_i.target_register_code];
endmodule // hdc_core_model

// ---- tb/hdc_top_tb.sv ----
// self-checking bench for the halting debug control block
`timescale 1ns/1ps
module hdc_top_tb;
  import hdc_pkg::*;
  logic              mclk_i = 1'b0;
  logic              arst_n_i = 1'b0;
  logic              ce_i = 1'b1;
  hdc_acc_t          acc_i = '0;
  logic [31:0]       rdata_o;
  logic              rvalid_o;
  logic              in_debug_i = 1'b0;
  logic              debug_en_o;
  logic              halt_req_o;
  logic              step_en_o;
  logic              pended_service_call_i = 1'b1;
  logic              system_tick_interrupt_i = 1'b1;
  logic [31:0]       ext_irq_i = 32'h5A5A_C3C3;
  logic              nmi_i = 1'b1;
  logic              pended_service_call_o;
  logic              system_tick_interrupt_o;
  logic [31:0]       ext_irq_o;
  logic              nmi_o;
  hdc_xreq_t         xreq_o;
  logic              xfer_done_i;
  logic [31:0]       xfer_rdata_i;
  logic [3:0]        delay = 4'h0;
  int                miscompares = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  logic              sink_valid;
  logic [31:0]       sink_data;

  hdc_top dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .acc_i(acc_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .in_debug_i(in_debug_i),
    .debug_en_o(debug_en_o), .halt_req_o(halt_req_o), .step_en_o(step_en_o),
    .pended_service_call_i(pended_service_call_i), .system_tick_interrupt_i(system_tick_interrupt_i), .ext_irq_i(ext_irq_i), .nmi_i(nmi_i),
    .pended_service_call_o(pended_service_call_o), .system_tick_interrupt_o(system_tick_interrupt_o), .ext_irq_o(ext_irq_o), .nmi_o(nmi_o),
    .xreq_o(xreq_o), .xfer_done_i(xfer_done_i), .xfer_rdata_i(xfer_rdata_i));
  hdc_core_model core_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .xreq_i(xreq_o),
    .delay_i(delay), .done_o(xfer_done_i), .rdata_o(xfer_rdata_i));

  always #4 mclk_i = ~mclk_i;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access at a falling edge, answer taken, then one idle cycle
  task automatic acc(input logic w, input logic debug_access_port, input logic [1:0] sel,
                     input logic [31:0] d, output logic rv, output logic [31:0] rdv);
    acc_i = '{1'b1, w, debug_access_port, sel, d};
    @(negedge mclk_i);
    rv  = rvalid_o;
    rdv = rdata_o;
    acc_i.valid = 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [31:0] d);
    logic        rv;
    logic [31:0] rdv;
    acc(1'b1, 1'b1, sel, d, rv, rdv);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
    logic        rv;
    logic [31:0] rdv;
    acc(1'b0, 1'b1, sel, 32'h0000_0000, rv, rdv);
    chk({31'h0, rv}, 32'h0000_0001);
    chk(rdv, exp);
  endtask
  task automatic outs(input logic [2:0] exp);
    chk({29'h0, debug_en_o, halt_req_o, step_en_o}, {29'h0, exp});
  endtask
  task automatic chk_irq(input logic masked);
    chk({29'h0, pended_service_call_o, system_tick_interrupt_o, nmi_o}, masked ? 32'h0000_0001 : 32'h0000_0007);
    chk(ext_irq_o, masked ? 32'h0000_0000 : 32'h5A5A_C3C3);
  endtask
  task automatic poll_ready();
    int          n;
    logic        rv;
    logic [31:0] v;
    n = 0;
    v = 32'h0000_0000;
    while (v[16] !== 1'b1 && n < 20) begin
      acc(1'b0, 1'b1, SEL_CTRL_STATUS, 32'h0000_0000, rv, v);
      n++;
    end
    chk(v, 32'h0003_0003);
  endtask

  initial begin
    repeat (6) @(negedge mclk_i);
    arst_n_i = 1'b1;
    @(negedge mclk_i);
    outs(3'b000);
    rd(SEL_CTRL_STATUS, 32'h0001_0000);
    chk_irq(1'b0);
    $display("test reset done");
    wr(SEL_CTRL_STATUS, 32'h0000_0001);
    rd(SEL_CTRL_STATUS, 32'h0001_0000);
    acc(1'b1, 1'b0, SEL_CTRL_STATUS, 32'hA05F_0007, sink_valid, sink_data);
    rd(SEL_CTRL_STATUS, 32'h0001_0006);
    outs(3'b000);
    $display("test key and source done");
    wr(SEL_CTRL_STATUS, 32'hA05F_0001);
    outs(3'b100);
    wr(SEL_CTRL_STATUS, 32'hA05F_0003);
    outs(3'b110);
    wr(SEL_CTRL_STATUS, 32'hA05F_000B);
    rd(SEL_CTRL_STATUS, 32'h0001_000B);
    chk_irq(1'b1);
    wr(SEL_CTRL_STATUS, 32'hA05F_000F);
    outs(3'b111);
    wr(SEL_CTRL_STATUS, 32'hA05F_000B);
    outs(3'b110);
    wr(SEL_CTRL_STATUS, 32'hA05F_000A);
    rd(SEL_CTRL_STATUS, 32'h0001_0002);
    chk_irq(1'b0);
    outs(3'b000);
    wr(SEL_CTRL_STATUS, 32'hA05F_0001);
    outs(3'b100);
    wr(SEL_CTRL_STATUS, 32'hA05F_0003);
    $display("test control bits done");
    wr(SEL_XFER_SELECT, 32'h0001_0005);
    chk({31'h0, xreq_o.valid}, 32'h0000_0000);
    rd(SEL_CTRL_STATUS, 32'h0001_0003);
    in_debug_i = 1'b1;
    delay = 4'h6;
    wr(SEL_XFER_DATA, 32'hCAFE_0001);
    wr(SEL_XFER_SELECT, 32'h0001_0005);
    chk({25'h0, xreq_o.valid, xreq_o.dir, xreq_o.target_register_code}, 32'h0000_0065);
    chk(xreq_o.wdata, 32'hCAFE_0001);
    rd(SEL_CTRL_STATUS, 32'h0002_0003);
    wr(SEL_XFER_SELECT, 32'h0000_0007);
    chk({25'h0, xreq_o.valid, xreq_o.dir, xreq_o.target_register_code}, 32'h0000_0065);
    poll_ready();
    delay = 4'h0;
    wr(SEL_XFER_DATA, 32'h0000_0000);
    wr(SEL_XFER_SELECT, 32'h0000_0005);
    poll_ready();
    rd(SEL_XFER_DATA, 32'hCAFE_0001);
    rd(2'h3, 32'h0000_0000);
    $display("test transfers done");
    test_done();
  end
endmodule // hdc_top_tb
